// ===== logic/ir_port_pkg.sv
// Shared constants and types for the infrared port control block
package ir_port_pkg;

  // ****************************************************************
  // Register indices and reset values
  // ****************************************************************
  localparam logic [1:0] PRIMARY_IDX = 2'h0;
  localparam logic [1:0] SECONDARY_IDX = 2'h1;
  localparam logic [1:0] STATUS_IDX = 2'h2;
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [7:0] SECONDARY_RW_MASK = 8'h7f;

  // ****************************************************************
  // Carrier prediction and timer sizes
  // ****************************************************************
  localparam int GAP_W = 5;
  localparam logic [GAP_W-1:0] CARRIER_PERIOD = 5'h10;
  localparam logic [GAP_W-1:0] TOL_NARROW = 5'h03;
  localparam logic [GAP_W-1:0] TOL_WIDE = 5'h04;
  localparam logic [GAP_W-1:0] GAP_MAX = 5'h1f;
  localparam int PULSE_TIMER_W = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic tx_queue_enable;
    logic rx_queue_enable;
    logic modulation_enable;
    logic carrier_detect_enable;
    logic [1:0] pulse_trigger_polarity;
    logic [1:0] edge_tolerance_select;
  } primary_t;

  typedef struct packed {
    logic reserved;
    logic overflow_load_disable;
    logic loopback_store;
    logic carrier_sense_invert;
    logic [3:0] other_store;
  } secondary_t;

  typedef struct packed {
    logic level;
    logic [PULSE_TIMER_W-1:0] width;
  } rx_entry_t;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

endpackage : ir_port_pkg

// ===== logic/ir_port_control.sv
// Infrared port control: registers, queues, modulator and demodulator
// How it works
// - Clearing transmit queue enable disables and zeroes the transmit queue.
// - Clearing receive queue enable disables and zeroes the receive queue.
// - Without carrier keying the pin carries plain data levels.
// - With carrier keying a mark toggles the pin, a space stays quiet.
// - Polarity bit chooses whether ones or zeros become marks or highs.
// - Without carrier detection the receive pin is taken as plain levels.
// - With carrier detection toggling means mark, quiet means space, polarity applied.
// - Trigger field picks none, falling, rising or both demodulated edges.
// - Each selected edge ends the running width measurement and starts another.
// - Tolerance field sets window around 16 clocks: 3/3, 4/3, 3/4, 4/4.
// - After a burst's first rise, later rises must fall in window, else absent.
// - Timer overflow loads ones plus line level unless overflow loading is off.
// - Unmodulated idle pin rests low, or high when polarity is inverted.
//
// Decided for this implementation: the plain strobed port and the register offsets.

// ****************************************************************
// Two-entry buffer with flush
// ****************************************************************
module ir_pair_buffer #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [1:0][W-1:0] mem_q, mem_d;
  logic [1:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic valid_q, valid_d;
  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (valid_q && out_ready_in) begin
      mem_d[0] = mem_q[1];
      mem_d[1] = '0;
      cnt_d = cnt_q - 2'h1;
    end
    if (in_valid_in && ready_q) begin
      mem_d[cnt_d[0]] = in_data_in;
      cnt_d = cnt_d + 2'h1;
    end
    if (flush_in) begin
      mem_d = '0;
      cnt_d = 2'h0;
    end
    ready_d = !flush_in && (cnt_d != 2'h2);
    valid_d = (cnt_d != 2'h0);
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mem_q <= '0;
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end
  assign in_ready_out = ready_q;
  assign out_valid_out = valid_q;
  assign out_data_out = mem_q[0];
endmodule : ir_pair_buffer

// ****************************************************************
// Top level
// ****************************************************************
module ir_port_control #(
  parameter int BIT_CYCLES = 32,
  parameter int CARRIER_HALF = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic tx_valid_in,
  input wire logic tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output ir_port_pkg::rx_entry_t rx_data_out,
  input wire logic rx_ready_in,
  input wire logic rx_pin_in,
  output logic infrared_out_pin_out
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  ir_port_pkg::primary_t primary_q, primary_d;
  ir_port_pkg::secondary_t secondary_q, secondary_d;
  logic [7:0] rdata_q, rdata_d;
  logic rx_dropped_q, rx_dropped_d;
  ir_port_pkg::tx_state_t tx_state_q, tx_state_d;
  logic pin_q, pin_d;
  logic carrier_q, carrier_d;
  logic rx_line_level_q, rx_line_level_d;
  logic rx_push;
  logic rx_in_ready;
  always_comb begin
    primary_d = primary_q;
    secondary_d = secondary_q;
    rdata_d = 8'h00;
    if (wr_in && addr_in == ir_port_pkg::PRIMARY_IDX) begin
      primary_d = wdata_in;
    end
    if (wr_in && addr_in == ir_port_pkg::SECONDARY_IDX) begin
      secondary_d = wdata_in & ir_port_pkg::SECONDARY_RW_MASK;
    end
    if (rd_in) begin
      case (addr_in)
        ir_port_pkg::PRIMARY_IDX: rdata_d = primary_q;
        ir_port_pkg::SECONDARY_IDX: rdata_d = secondary_q & ir_port_pkg::SECONDARY_RW_MASK;
        ir_port_pkg::STATUS_IDX: rdata_d = {3'h0, tx_state_q == ir_port_pkg::TX_SEND, pin_q,
                                            rx_line_level_q, carrier_q, rx_dropped_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // A drop seen as the queue is switched off still counts
    rx_dropped_d = (rx_dropped_q && primary_q.rx_queue_enable) || (rx_push && !rx_in_ready);
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      primary_q <= ir_port_pkg::PRIMARY_RESET;
      secondary_q <= ir_port_pkg::SECONDARY_RESET;
      rdata_q <= 8'h00;
      rx_dropped_q <= 1'b0;
    end else begin
      primary_q <= primary_d;
      secondary_q <= secondary_d;
      rdata_q <= rdata_d;
      rx_dropped_q <= rx_dropped_d;
    end
  end
  assign rdata_out = rdata_q;
  // ****************************************************************
  // Queues
  // ****************************************************************
  logic tx_head_valid;
  logic tx_head_data;
  logic tx_pop;
  ir_port_pkg::rx_entry_t rx_entry;
  ir_pair_buffer #(.W(1)) tx_queue (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .flush_in(!primary_q.tx_queue_enable),
    .in_valid_in(tx_valid_in),
    .in_data_in(tx_data_in),
    .in_ready_out(tx_ready_out),
    .out_valid_out(tx_head_valid),
    .out_data_out(tx_head_data),
    .out_ready_in(tx_pop)
  );
  // Pin side cannot stall: a full queue drops and flags it
  ir_pair_buffer #(.W(1 + ir_port_pkg::PULSE_TIMER_W)) rx_queue (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .flush_in(!primary_q.rx_queue_enable),
    .in_valid_in(rx_push),
    .in_data_in(rx_entry),
    .in_ready_out(rx_in_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic tx_bit_q, tx_bit_d;
  logic [15:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] car_cnt_q, car_cnt_d;
  logic tx_level;
  logic bit_end;
  logic tx_mark;
  always_comb begin
    tx_state_d = tx_state_q;
    tx_bit_d = tx_bit_q;
    bit_cnt_d = bit_cnt_q;
    car_cnt_d = car_cnt_q;
    pin_d = pin_q;
    tx_pop = 1'b0;
    tx_level = tx_bit_q ^ secondary_q.carrier_sense_invert;
    bit_end = (bit_cnt_q == 16'(BIT_CYCLES - 1));
    tx_mark = (tx_state_q == ir_port_pkg::TX_SEND) && primary_q.modulation_enable && tx_level;
    case (tx_state_q)
      ir_port_pkg::TX_IDLE: begin
        pin_d = primary_q.modulation_enable ? 1'b0 : secondary_q.carrier_sense_invert;
        car_cnt_d = 8'h00;
        if (tx_head_valid) begin
          tx_pop = 1'b1;
          tx_bit_d = tx_head_data;
          bit_cnt_d = 16'h0000;
          tx_state_d = ir_port_pkg::TX_SEND;
        end
      end
      ir_port_pkg::TX_SEND: begin
        bit_cnt_d = bit_cnt_q + 16'h0001;
        if (!primary_q.modulation_enable) begin
          pin_d = tx_level;
          car_cnt_d = 8'h00;
        end else if (tx_level) begin
          if (car_cnt_q == 8'(CARRIER_HALF - 1)) begin
            car_cnt_d = 8'h00;
            pin_d = !pin_q;
          end else begin
            car_cnt_d = car_cnt_q + 8'h01;
          end
        end else begin
          pin_d = 1'b0;
          car_cnt_d = 8'h00;
        end
        if (bit_end) begin
          bit_cnt_d = 16'h0000;
          if (tx_head_valid) begin
            tx_pop = 1'b1;
            tx_bit_d = tx_head_data;
          end else begin
            tx_state_d = ir_port_pkg::TX_IDLE;
          end
        end
      end
      default: tx_state_d = ir_port_pkg::TX_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_state_q <= ir_port_pkg::TX_IDLE;
      tx_bit_q <= 1'b0;
      bit_cnt_q <= 16'h0000;
      car_cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_bit_q <= tx_bit_d;
      bit_cnt_q <= bit_cnt_d;
      car_cnt_q <= car_cnt_d;
      pin_q <= pin_d;
    end
  end
  assign infrared_out_pin_out = pin_q;
  // ****************************************************************
  // Receiver: carrier detect, edge select, pulse timer
  // ****************************************************************
  function automatic logic [ir_port_pkg::GAP_W-1:0] win_limit(input logic wide);
    win_limit = wide ? ir_port_pkg::TOL_WIDE : ir_port_pkg::TOL_NARROW;
  endfunction : win_limit
  logic rx_prev_q, rx_prev_d;
  logic [ir_port_pkg::GAP_W-1:0] gap_q, gap_d;
  logic [ir_port_pkg::GAP_W-1:0] lower;
  logic [ir_port_pkg::GAP_W-1:0] upper;
  logic level_prev_q, level_prev_d;
  logic [ir_port_pkg::PULSE_TIMER_W-1:0] timer_q, timer_d;
  logic rx_rise;
  logic edge_hit;
  logic timer_ovf;
  always_comb begin
    rx_prev_d = rx_pin_in;
    rx_rise = rx_pin_in && !rx_prev_q;
    lower = ir_port_pkg::CARRIER_PERIOD - win_limit(primary_q.edge_tolerance_select[0]);
    upper = ir_port_pkg::CARRIER_PERIOD + win_limit(primary_q.edge_tolerance_select[1]);
    gap_d = (gap_q == ir_port_pkg::GAP_MAX) ? gap_q : gap_q + 5'h01;
    carrier_d = carrier_q;
    if (rx_rise) begin
      gap_d = 5'h01;
      // An off-window rise drops the carrier; the next rise restarts it
      carrier_d = !carrier_q || (gap_q >= lower && gap_q <= upper);
    end else if (gap_q > upper) begin
      carrier_d = 1'b0;
    end
    rx_line_level_d = (primary_q.carrier_detect_enable ? carrier_q : rx_pin_in)
                      ^ secondary_q.carrier_sense_invert;
    level_prev_d = rx_line_level_q;
    edge_hit = (primary_q.pulse_trigger_polarity[0] && level_prev_q && !rx_line_level_q)
            || (primary_q.pulse_trigger_polarity[1] && !level_prev_q && rx_line_level_q);
    timer_ovf = 1'b0;
    rx_push = 1'b0;
    rx_entry = '0;
    timer_d = timer_q + 16'h0001;
    if (primary_q.pulse_trigger_polarity == 2'h0) begin
      timer_d = 16'h0000;
    end else if (edge_hit) begin
      rx_push = primary_q.rx_queue_enable;
      rx_entry = {level_prev_q, timer_q};
      timer_d = 16'h0000;
    end else if (timer_q == '1) begin
      timer_ovf = 1'b1;
      rx_push = primary_q.rx_queue_enable && !secondary_q.overflow_load_disable;
      rx_entry = {rx_line_level_q, timer_q};
      timer_d = 16'h0000;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rx_prev_q <= 1'b0;
      gap_q <= ir_port_pkg::GAP_MAX;
      carrier_q <= 1'b0;
      rx_line_level_q <= 1'b0;
      level_prev_q <= 1'b0;
      timer_q <= 16'h0000;
    end else begin
      rx_prev_q <= rx_prev_d;
      gap_q <= gap_d;
      carrier_q <= carrier_d;
      rx_line_level_q <= rx_line_level_d;
      level_prev_q <= level_prev_d;
      timer_q <= timer_d;
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  a_txq_flush_ready: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !primary_q.tx_queue_enable |=> !tx_ready_out)
    else $error("tx queue ready while disabled");
  a_rxq_flush_empty: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !primary_q.rx_queue_enable |=> !rx_valid_out && rx_data_out == '0)
    else $error("rx queue not cleared while disabled");
  a_plain_tx_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tx_state_q == ir_port_pkg::TX_SEND && !primary_q.modulation_enable
    |=> pin_q == ($past(tx_bit_q) ^ $past(secondary_q.carrier_sense_invert)))
    else $error("plain tx level wrong");
  a_mark_toggles: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tx_mark && car_cnt_q == 8'(CARRIER_HALF - 1) |=> pin_q != $past(pin_q))
    else $error("mark carrier did not toggle");
  a_space_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tx_state_q == ir_port_pkg::TX_SEND && primary_q.modulation_enable && !tx_level
    |=> !pin_q)
    else $error("space not quiet");
  a_idle_rest: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tx_state_q == ir_port_pkg::TX_IDLE && !primary_q.modulation_enable
    |=> pin_q == $past(secondary_q.carrier_sense_invert))
    else $error("idle level wrong");
  a_raw_rx_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !primary_q.carrier_detect_enable
    |=> rx_line_level_q == ($past(rx_pin_in) ^ $past(secondary_q.carrier_sense_invert)))
    else $error("raw rx level wrong");
  a_carrier_lost: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    carrier_q && !rx_rise && gap_q > upper |=> !carrier_q)
    else $error("carrier kept past window");
  a_carrier_window: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    carrier_q && rx_rise && (gap_q < lower || gap_q > upper) |=> !carrier_q)
    else $error("off-window rise accepted");
  a_edge_restart: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    edge_hit && primary_q.pulse_trigger_polarity != 2'h0 |=> timer_q == 16'h0000)
    else $error("timer not restarted on edge");
  a_ovf_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    timer_ovf |-> rx_push == (primary_q.rx_queue_enable && !secondary_q.overflow_load_disable)
      && rx_entry.width == '1)
    else $error("overflow load wrong");
  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rd_in && addr_in == ir_port_pkg::SECONDARY_IDX |=> !rdata_out[7])
    else $error("reserved bit read nonzero");
endmodule : ir_port_control

// ===== verification/ir_far_end.sv
// Far-side model: infrared receiver module driving the receive pin
module ir_far_end (
  input wire logic mclk_in,
  output logic rx_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Line drive
  // ****************************************************************
  // Receiver module output rests low between frames
  initial rx_pin_out = 1'b0;

  task automatic hold(input logic v, input int n);
    rx_pin_out <= v;
    repeat (n) @(posedge mclk_in);
  endtask : hold

  // One rise per period, roughly even duty
  task automatic burst(input int p, input int n);
    repeat (n) begin
      hold(1'b1, p / 2);
      hold(1'b0, p - p / 2);
    end
  endtask : burst
endmodule : ir_far_end

// ===== verification/tb_top.sv
// Testbench for the infrared port control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic mclk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, v;
  logic tx_valid_in = 1'b0, tx_data_in = 1'b0, rx_ready_in = 1'b1;
  logic tx_ready_out, rx_valid_out, pin, rx_pin, all_on, inv, d, e;
  ir_port_pkg::rx_entry_t rx_data_out;
  ir_port_pkg::rx_entry_t got[$];
  logic pin_log[$];
  int error_cnt = 0, tests_run = 0, t0, n, h, l, p;

  always #5 mclk_in = ~mclk_in;

  // Small bit time keeps the run short; carrier still toggles inside a bit
  ir_port_control #(.BIT_CYCLES(8), .CARRIER_HALF(2)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
    .rx_data_out(rx_data_out), .rx_ready_in(rx_ready_in), .rx_pin_in(rx_pin),
    .infrared_out_pin_out(pin));
  ir_far_end far (.mclk_in(mclk_in), .rx_pin_out(rx_pin));

  // Pin history and received entries, sampled before the edge updates
  always @(posedge mclk_in) begin
    pin_log.push_back(pin);
    if (rx_valid_out && rx_ready_in)
      got.push_back(rx_data_out);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] dat);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= dat;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] dat);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 dat = rdata_out;
  endtask : rd

  task automatic push(input logic b);
    int k;
    logic r;
    @(posedge mclk_in);
    tx_valid_in <= 1'b1;
    tx_data_in <= b;
    for (k = 0; k < 100; k++) begin
      #1 r = tx_ready_out;
      @(posedge mclk_in);
      if (r === 1'b1)
        break;
    end
    tx_valid_in <= 1'b0;
    if (k == 100) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : push

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    v = $urandom(32'hf84b19e3);
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(2'h0, v);
    chk(v, ir_port_pkg::PRIMARY_RESET);
    chk(tx_ready_out, 1'b0);
    rd(2'h3, v);
    chk(v, 8'h00);
    v = 8'($urandom) & 8'h3f;
    wr(2'h0, v);
    rd(2'h0, l[7:0]);
    chk(l[7:0], v);
    wr(2'h1, 8'hff);
    rd(2'h1, v);
    chk(v, 8'h7f);
    // Plain levels, queue full, then flush mid-bit
    for (int k = 0; k < 2; k++) begin
      inv = k[0];
      wr(2'h1, {3'h0, inv, 4'h0});
      wr(2'h0, 8'h80);
      #1 chk(pin, inv);
      push(1'b1);
      #1 t0 = pin_log.size();
      push(1'b1);
      push(1'b1);
      @(posedge mclk_in);
      #1 chk(tx_ready_out, 1'b0);
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h80);
      repeat (30) @(posedge mclk_in);
      chk(pin_log[t0 + 6], !inv);
      // Without the flush the second queued bit would still be on the pin here
      chk(pin_log[t0 + 12], inv);
      #1 chk(pin, inv);
    end
    // Carrier keying: count toggles inside one bit
    for (int k = 0; k < 4; k++) begin
      inv = k[1];
      d = k[0];
      wr(2'h1, {3'h0, inv, 4'h0});
      wr(2'h0, 8'ha0);
      push(d);
      #1 t0 = pin_log.size();
      repeat (14) @(posedge mclk_in);
      n = 0;
      for (int i = t0 + 3; i <= t0 + 9; i++)
        n += int'(pin_log[i] != pin_log[i - 1]);
      chk(n != 0, d ^ inv);
    end
    // Edge selection and pulse widths on plain levels
    wr(2'h1, 8'h00);
    for (int tr = 0; tr < 4; tr++) begin
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h40 | 8'(tr << 2));
      got.delete();
      h = 5 + int'($urandom % 30);
      l = 5 + int'($urandom % 30);
      far.hold(1'b1, h);
      far.hold(1'b0, l);
      far.hold(1'b1, h);
      far.hold(1'b0, 10);
      chk(17'(got.size()), (tr == 3) ? 17'h4 : (tr == 0) ? 17'h0 : 17'h2);
      if (tr == 3) begin
        // Timer shows zero the cycle after an edge: n cycles read as n - 1
        chk(got[1], {1'b1, 16'(h - 1)});
        chk(got[2], {1'b0, 16'(l - 1)});
        chk(got[3], {1'b1, 16'(h - 1)});
      end else if (tr != 0)
        chk(got[1].width, 17'(h + l - 1));
    end
    t0 = got.size();
    repeat (65546) @(posedge mclk_in);
    #1 chk(17'(got.size()), 17'(t0 + 1));
    chk(got[t0], {1'b0, 16'hffff});
    // Receive queue overrun, then flush by disable
    @(posedge mclk_in);
    rx_ready_in <= 1'b0;
    far.hold(1'b1, 5);
    far.hold(1'b0, 5);
    far.hold(1'b1, 5);
    far.hold(1'b0, 5);
    rd(2'h2, v);
    chk(v[0], 1'b1);
    chk(rx_valid_out, 1'b1);
    wr(2'h0, 8'h00);
    // Flush lands one edge after the enable bit clears
    @(posedge mclk_in);
    #1 chk(rx_valid_out, 1'b0);
    chk(rx_data_out, 17'h0);
    @(posedge mclk_in);
    rx_ready_in <= 1'b1;
    // Carrier window: present must hold steady only inside the window
    wr(2'h1, 8'h40);
    for (int k = 0; k < 8; k++) begin
      p = k[0] ? 20 : 12;
      e = k[0] ? k[2] : k[1];
      wr(2'h0, 8'h10 | 8'(k >> 1));
      all_on = 1'b1;
      fork
        far.burst(p, 8);
        begin
          repeat (2 * p) @(posedge mclk_in);
          addr_in <= 2'h2;
          rd_in <= 1'b1;
          for (int i = 0; i < 4 * p; i++) begin
            @(posedge mclk_in);
            if (i > 1)
              all_on = all_on & rdata_out[1] & rdata_out[2];
          end
          rd_in <= 1'b0;
        end
      join
      chk(all_on, e);
      far.hold(1'b0, 40);
    end
    tally_and_finish();
  end
endmodule : tb_top
